/* File: shared/ctor_defines.vh */
`ifndef CTOR_DEFINES_VH
`define CTOR_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CTOR_IDX_CLK_ZERO     8'h41
`define CTOR_IDX_CLK_TRAIL    8'h42
`define CTOR_IDX_CLK_POST     8'h43
`define CTOR_IDX_DATA_PREP    8'h44
`define CTOR_IDX_DATA_ZERO    8'h45
`define CTOR_IDX_DATA_TRAIL   8'h46
`define CTOR_IDX_LANE_RATE    8'h48
`define CTOR_IDX_LINK_STATUS  8'h49

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTOR_OVERRIDE_BIT     7
`define CTOR_VALUE_MSB        6
`define CTOR_RATE_MSB         2
`define CTOR_ALIVE_BIT        0

// ----------------------------------------------------------------------
// reset values, all for the 800 Mbps lane rate
// ----------------------------------------------------------------------
`define CTOR_CLK_ZERO_RST     7'h1B
`define CTOR_CLK_TRAIL_RST    7'h0B
`define CTOR_CLK_POST_RST     7'h0A
`define CTOR_DATA_PREP_RST    7'h06
`define CTOR_DATA_ZERO_RST    7'h0C
`define CTOR_DATA_TRAIL_RST   7'h08
`define CTOR_OVERRIDE_RST     1'b0

// ----------------------------------------------------------------------
// lane rate codes and their scale in eighths of the 800 Mbps rate
// ----------------------------------------------------------------------
`define CTOR_RATE_400         3'h0
`define CTOR_RATE_800         3'h1
`define CTOR_RATE_1200        3'h2
`define CTOR_RATE_1500        3'h3
`define CTOR_RATE_1600        3'h4
`define CTOR_SCALE_400        5'h04
`define CTOR_SCALE_800        5'h08
`define CTOR_SCALE_1200       5'h0C
`define CTOR_SCALE_1500       5'h0F
`define CTOR_SCALE_1600       5'h10

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CTOR_SYS_CLK_MHZ      40
`define CTOR_ALIVE_TIMEOUT_NS 1600

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define CTOR_RESP_OKAY        2'h0
`define CTOR_RESP_SLVERR      2'h2

`endif

/* File: verilog/ctor_lane_timing_regs.v */
`timescale 1ns/1ps
`include "ctor_defines.vh"

// Summary of operation
// - clock-lane zero register: bit 7 override, low 7 bits value, reset 0x1B.
// - clock-lane trail register: bit 7 override, low 7 bits value, reset 0x0B.
// - clock-lane post register: bit 7 override, low 7 bits value, reset 0x0A.
// - data-lane prepare register: bit 7 override, low 7 bits value, reset 0x06.
// - data-lane zero register: bit 7 override, low 7 bits value, reset 0x0C.
// - data-lane trail register: bit 7 override, low 7 bits value, reset 0x08.
// - override clear: value writes ignored, reads return the computed value.
// - override set: value writable, reads return the last written value.
// - defaults match 800 Mbps; computed values follow a new lane rate.
// - all override flags reset to zero, so every timing starts automatic.

module ctor_lane_timing_regs #(
  parameter ADDR_WIDTH = 12                   // axi address width
) (
  input  wire                  sys_clk,       // register clock, 40 MHz
  input  wire                  reset_n,       // asynchronous reset
  input  wire                  laneByteClk,   // lane byte clock from the phy
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,  // write address
  input  wire                  s_axi_awvalid, // write address valid
  output wire                  s_axi_awready, // write address ready
  input  wire [31:0]           s_axi_wdata,   // write data
  input  wire [3:0]            s_axi_wstrb,   // write byte enables
  input  wire                  s_axi_wvalid,  // write data valid
  output wire                  s_axi_wready,  // write data ready
  output wire [1:0]            s_axi_bresp,   // write response
  output wire                  s_axi_bvalid,  // write response valid
  input  wire                  s_axi_bready,  // write response ready
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,  // read address
  input  wire                  s_axi_arvalid, // read address valid
  output wire                  s_axi_arready, // read address ready
  output wire [31:0]           s_axi_rdata,   // read data
  output wire [1:0]            s_axi_rresp,   // read response
  output wire                  s_axi_rvalid,  // read data valid
  input  wire                  s_axi_rready,  // read data ready
  output wire [6:0]            clkZeroValue,  // effective clock zero time
  output wire [6:0]            clkTrailValue, // effective clock trail time
  output wire [6:0]            clkPostValue,  // effective clock post time
  output wire [6:0]            dataPrepValue, // effective data prepare time
  output wire [6:0]            dataZeroValue, // effective data zero time
  output wire [6:0]            dataTrailValue,// effective data trail time
  output wire                  byteClkTick,   // one pulse per byte clock rise
  output wire                  byteClkAlive   // byte clock seen recently
);

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam NUM_TIMINGS  = 6;
  localparam ALIVE_CYCLES = (`CTOR_ALIVE_TIMEOUT_NS * `CTOR_SYS_CLK_MHZ) / 1000;
  localparam [7:0] ALIVE_LIMIT = ALIVE_CYCLES[7:0];
  localparam [41:0] RESET_VALUES = {`CTOR_DATA_TRAIL_RST, `CTOR_DATA_ZERO_RST,
                                    `CTOR_DATA_PREP_RST, `CTOR_CLK_POST_RST,
                                    `CTOR_CLK_TRAIL_RST, `CTOR_CLK_ZERO_RST};

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // maps a byte address to {hit, slot}; slots 0-5 timing, 6 rate, 7 status
  function [3:0] decodeAddr;
    input [ADDR_WIDTH-1:0] addr;
    reg   [7:0]            idx;
    begin
      idx = addr[9:2];
      decodeAddr = 4'h0;
      if (addr[1:0] == 2'b00 && addr[ADDR_WIDTH-1:10] == 0) begin
        case (idx)
          `CTOR_IDX_CLK_ZERO:    decodeAddr = 4'h8;
          `CTOR_IDX_CLK_TRAIL:   decodeAddr = 4'h9;
          `CTOR_IDX_CLK_POST:    decodeAddr = 4'hA;
          `CTOR_IDX_DATA_PREP:   decodeAddr = 4'hB;
          `CTOR_IDX_DATA_ZERO:   decodeAddr = 4'hC;
          `CTOR_IDX_DATA_TRAIL:  decodeAddr = 4'hD;
          `CTOR_IDX_LANE_RATE:   decodeAddr = 4'hE;
          `CTOR_IDX_LINK_STATUS: decodeAddr = 4'hF;
          default:               decodeAddr = 4'h0;
        endcase
      end
    end
  endfunction

  // scale in eighths of the 800 Mbps rate; unknown codes behave as 800
  function [4:0] rateScale;
    input [2:0] rate;
    begin
      case (rate)
        `CTOR_RATE_400:  rateScale = `CTOR_SCALE_400;
        `CTOR_RATE_1200: rateScale = `CTOR_SCALE_1200;
        `CTOR_RATE_1500: rateScale = `CTOR_SCALE_1500;
        `CTOR_RATE_1600: rateScale = `CTOR_SCALE_1600;
        default:         rateScale = `CTOR_SCALE_800;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg                  awreadyReg;
  reg                  wreadyReg;
  reg                  bvalidReg;
  reg [1:0]            brespReg;
  reg                  arreadyReg;
  reg                  rvalidReg;
  reg [1:0]            rrespReg;
  reg [31:0]           rdataReg;
  reg                  awHeldReg;
  reg                  wHeldReg;
  reg [ADDR_WIDTH-1:0] awAddrReg;
  reg [7:0]            wByteReg;
  reg                  wStrbReg;
  reg [2:0]            laneRateReg;
  reg [NUM_TIMINGS-1:0] overrideReg;
  reg [41:0]           manualReg;
  reg [41:0]           autoReg;
  reg [41:0]           effectiveReg;
  reg [2:0]            byteClkSyncReg;
  reg                  byteClkLevelReg;
  reg                  tickReg;
  reg [7:0]            aliveCountReg;
  reg                  aliveReg;

  wire       doWrite  = awHeldReg && wHeldReg && !bvalidReg;
  wire [3:0] wrDecode = decodeAddr(awAddrReg);
  wire [3:0] rdDecode = decodeAddr(s_axi_araddr);
  wire       wrByte0  = doWrite && wStrbReg && wrDecode[3];

  // ----------------------------------------------------------------------
  // per-timing override, stored value, computed value and output
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TIMINGS; g = g + 1) begin : gTiming
      wire [11:0] scaled = RESET_VALUES[7*g +: 7] * rateScale(laneRateReg);
      wire [11:0] rounded = scaled + 12'h004;
      wire        hitMe = wrByte0 && (wrDecode[2:0] == g);

      // override flag and manual value; the value only lands when the same
      // write leaves the flag set, so a write with the flag clear only clears the flag
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          overrideReg[g]      <= `CTOR_OVERRIDE_RST;
          manualReg[7*g +: 7] <= RESET_VALUES[7*g +: 7];
        end else if (hitMe) begin
          overrideReg[g] <= wByteReg[`CTOR_OVERRIDE_BIT];
          if (wByteReg[`CTOR_OVERRIDE_BIT]) begin
            manualReg[7*g +: 7] <= wByteReg[`CTOR_VALUE_MSB:0];
          end
        end
      end

      // computed value tracks the lane rate, rounded to whole byte clocks
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          autoReg[7*g +: 7] <= RESET_VALUES[7*g +: 7];
        end else begin
          autoReg[7*g +: 7] <= rounded[9:3];
        end
      end

      // value handed to the transmitter; a manual value ignores rate changes
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          effectiveReg[7*g +: 7] <= RESET_VALUES[7*g +: 7];
        end else if (overrideReg[g]) begin
          effectiveReg[7*g +: 7] <= manualReg[7*g +: 7];
        end else begin
          effectiveReg[7*g +: 7] <= autoReg[7*g +: 7];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // lane rate select
  // ----------------------------------------------------------------------
  // a new rate changes only the computed values, one cycle later
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      laneRateReg <= `CTOR_RATE_800;
    end else if (wrByte0 && wrDecode[2:0] == 3'h6) begin
      laneRateReg <= wByteReg[`CTOR_RATE_MSB:0];
    end
  end

  // ----------------------------------------------------------------------
  // byte clock sampling
  // ----------------------------------------------------------------------
  // three stages; a level change counts once stages two and three agree
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byteClkSyncReg  <= 3'h0;
      byteClkLevelReg <= 1'b0;
      tickReg         <= 1'b0;
    end else begin
      byteClkSyncReg <= {byteClkSyncReg[1:0], laneByteClk};
      tickReg        <= 1'b0;
      if (byteClkSyncReg[1] == byteClkSyncReg[2]) begin
        byteClkLevelReg <= byteClkSyncReg[2];
        tickReg         <= byteClkSyncReg[2] && !byteClkLevelReg;
      end
    end
  end

  // the byte clock stops between frames, so liveness is only a hint
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aliveCountReg <= 8'h00;
      aliveReg      <= 1'b0;
    end else if (tickReg) begin
      aliveCountReg <= 8'h00;
      aliveReg      <= 1'b1;
    end else if (aliveCountReg == ALIVE_LIMIT) begin
      aliveReg <= 1'b0;
    end else begin
      aliveCountReg <= aliveCountReg + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channels
  // ----------------------------------------------------------------------
  // address and data are caught separately; the write lands the cycle after
  // both are held, and neither ready rises again until the response is taken
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      awreadyReg <= 1'b1;
      wreadyReg  <= 1'b1;
      awHeldReg  <= 1'b0;
      wHeldReg   <= 1'b0;
      awAddrReg  <= {ADDR_WIDTH{1'b0}};
      wByteReg   <= 8'h00;
      wStrbReg   <= 1'b0;
      bvalidReg  <= 1'b0;
      brespReg   <= `CTOR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awreadyReg) begin
        awHeldReg  <= 1'b1;
        awAddrReg  <= s_axi_awaddr;
        awreadyReg <= 1'b0;
      end
      if (s_axi_wvalid && wreadyReg) begin
        wHeldReg  <= 1'b1;
        wByteReg  <= s_axi_wdata[7:0];
        wStrbReg  <= s_axi_wstrb[0];
        wreadyReg <= 1'b0;
      end
      if (doWrite) begin
        awHeldReg <= 1'b0;
        wHeldReg  <= 1'b0;
        bvalidReg <= 1'b1;
        brespReg  <= wrDecode[3] ? `CTOR_RESP_OKAY : `CTOR_RESP_SLVERR;
      end
      if (bvalidReg && s_axi_bready) begin
        bvalidReg  <= 1'b0;
        awreadyReg <= 1'b1;
        wreadyReg  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channels
  // ----------------------------------------------------------------------
  // read data is captured at the address handshake and held until taken
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arreadyReg <= 1'b1;
      rvalidReg  <= 1'b0;
      rrespReg   <= `CTOR_RESP_OKAY;
      rdataReg   <= 32'h0000_0000;
    end else begin
      if (s_axi_arvalid && arreadyReg) begin
        arreadyReg <= 1'b0;
        rvalidReg  <= 1'b1;
        rrespReg   <= rdDecode[3] ? `CTOR_RESP_OKAY : `CTOR_RESP_SLVERR;
        rdataReg   <= 32'h0000_0000;
        if (rdDecode[3]) begin
          case (rdDecode[2:0])
            3'h6:    rdataReg[`CTOR_RATE_MSB:0] <= laneRateReg;
            3'h7:    rdataReg[`CTOR_ALIVE_BIT] <= aliveReg;
            default: begin
              rdataReg[`CTOR_OVERRIDE_BIT] <= overrideReg[rdDecode[2:0]];
              rdataReg[`CTOR_VALUE_MSB:0]  <= overrideReg[rdDecode[2:0]] ?
                manualReg[7*rdDecode[2:0] +: 7] :
                autoReg[7*rdDecode[2:0] +: 7];
            end
          endcase
        end
      end
      if (rvalidReg && s_axi_rready) begin
        rvalidReg  <= 1'b0;
        arreadyReg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign s_axi_awready  = awreadyReg;
  assign s_axi_wready   = wreadyReg;
  assign s_axi_bresp    = brespReg;
  assign s_axi_bvalid   = bvalidReg;
  assign s_axi_arready  = arreadyReg;
  assign s_axi_rdata    = rdataReg;
  assign s_axi_rresp    = rrespReg;
  assign s_axi_rvalid   = rvalidReg;
  assign clkZeroValue   = effectiveReg[6:0];
  assign clkTrailValue  = effectiveReg[13:7];
  assign clkPostValue   = effectiveReg[20:14];
  assign dataPrepValue  = effectiveReg[27:21];
  assign dataZeroValue  = effectiveReg[34:28];
  assign dataTrailValue = effectiveReg[41:35];
  assign byteClkTick    = tickReg;
  assign byteClkAlive   = aliveReg;

endmodule // ctor_lane_timing_regs

/* File: sim/ctor_byte_clk_model.sv */
`timescale 1ns/1ps
// --------------------------------
// far-side phy: lane byte clock
// --------------------------------
module ctor_byte_clk_model (
  input  wire en,         // run the byte clock
  output reg  laneByteClk // 200 ns period when running
);
  // the clock parks low when idle, so no stale edges reach the block
  initial begin
    laneByteClk = 1'b0;
    #7;
    forever begin
      #100;
      laneByteClk = en ? ~laneByteClk : 1'b0;
    end
  end
endmodule // ctor_byte_clk_model

/* File: sim/ctor_lane_timing_monitor.sv */
`timescale 1ns/1ps
`include "ctor_defines.vh"
// --------------------------------
// bus and link checker
// --------------------------------
module ctor_lane_timing_monitor (
  input wire        sys_clk,        // clock
  input wire        reset_n,        // reset
  input wire        laneByteClk,    // byte clock
  input wire        s_axi_awvalid,  // aw valid
  input wire        s_axi_awready,  // aw ready
  input wire        s_axi_wvalid,   // w valid
  input wire        s_axi_wready,   // w ready
  input wire [1:0]  s_axi_bresp,    // b resp
  input wire        s_axi_bvalid,   // b valid
  input wire        s_axi_bready,   // b ready
  input wire        s_axi_arvalid,  // ar valid
  input wire        s_axi_arready,  // ar ready
  input wire [31:0] s_axi_rdata,    // r data
  input wire [1:0]  s_axi_rresp,    // r resp
  input wire        s_axi_rvalid,   // r valid
  input wire        s_axi_rready,   // r ready
  input wire [6:0]  clkZeroValue,   // clock zero
  input wire [6:0]  dataTrailValue, // data trail
  input wire        byteClkTick,    // tick
  input wire        byteClkAlive    // alive
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // defaults are seen on the first edge out of reset
  a_reset_values: assert property ($rose(reset_n) |->
    clkZeroValue == `CTOR_CLK_ZERO_RST && dataTrailValue == `CTOR_DATA_TRAIL_RST)
    else $error("timing outputs off their defaults after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed while held");
  a_read_error: assert property (s_axi_rvalid &&
    s_axi_rresp == `CTOR_RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  a_tick_follows: assert property ($rose(laneByteClk) |-> ##[2:5] byteClkTick)
    else $error("byte clock rise missed");
  a_tick_single: assert property (byteClkTick |=> !byteClkTick)
    else $error("tick wider than one cycle");
  a_alive_on_tick: assert property (byteClkTick |=> byteClkAlive)
    else $error("alive not set by tick");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == `CTOR_RESP_SLVERR);
  c_tick: cover property (byteClkTick ##1 byteClkAlive);
endmodule // ctor_lane_timing_monitor

bind ctor_lane_timing_regs ctor_lane_timing_monitor monInst (
  .sys_clk, .reset_n, .laneByteClk, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .clkZeroValue, .dataTrailValue, .byteClkTick, .byteClkAlive
);

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "ctor_defines.vh"
module tb_top;
  // --------------------------------
  // signals
  // --------------------------------
  reg         sys_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, phyEnable;
  reg  [11:0] s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  wire        laneByteClk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, byteClkTick, byteClkAlive;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0]  outv [0:5];
  int         errors, samples_checked, cycleCount;
  // 800 Mbps defaults in register order; rate scale in eighths per code
  logic [6:0] dflt [0:5] = '{`CTOR_CLK_ZERO_RST, `CTOR_CLK_TRAIL_RST, `CTOR_CLK_POST_RST,
    `CTOR_DATA_PREP_RST, `CTOR_DATA_ZERO_RST, `CTOR_DATA_TRAIL_RST};
  int         scale [0:4] = '{4, 8, 12, 15, 16};

  ctor_lane_timing_regs uut (
    .sys_clk, .reset_n, .laneByteClk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clkZeroValue(outv[0]),
    .clkTrailValue(outv[1]), .clkPostValue(outv[2]), .dataPrepValue(outv[3]),
    .dataZeroValue(outv[4]), .dataTrailValue(outv[5]), .byteClkTick, .byteClkAlive
  );
  ctor_byte_clk_model phyModel (.en(phyEnable), .laneByteClk);

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic [11:0] ba(input int idx);
    ba = 12'(idx * 4);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ready is raised only once valid shows, so the held-answer case is always hit
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h00_0000, ed}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    for (int k = 0; k < 6; k++) begin
      rd(ba(`CTOR_IDX_CLK_ZERO + k), {1'b0, dflt[k]}, `CTOR_RESP_OKAY);
      chk("timing output", dflt[k], outv[k]);
    end
    rd(ba(`CTOR_IDX_LANE_RATE), 8'h01, `CTOR_RESP_OKAY);
    $display("test reset done");
  endtask
  // set, read back, then clear each override; 7F-k reaches the top of the field
  task automatic t_override();
    for (int k = 0; k < 6; k++) begin
      wr(ba(`CTOR_IDX_CLK_ZERO + k), 8'hFF - k, `CTOR_RESP_OKAY);
      rd(ba(`CTOR_IDX_CLK_ZERO + k), 8'hFF - k, `CTOR_RESP_OKAY);
      chk("timing output", 7'h7F - k, outv[k]);
      wr(ba(`CTOR_IDX_CLK_ZERO + k), 8'h55, `CTOR_RESP_OKAY);
      rd(ba(`CTOR_IDX_CLK_ZERO + k), {1'b0, dflt[k]}, `CTOR_RESP_OKAY);
      chk("timing output", dflt[k], outv[k]);
    end
    $display("test override done");
  endtask
  // the five defined rate codes; register 0 stays overridden and must not move
  task automatic t_rate();
    logic [6:0] e;
    wr(ba(`CTOR_IDX_CLK_ZERO), 8'hD5, `CTOR_RESP_OKAY);
    for (int r = 0; r < 5; r++) begin
      wr(ba(`CTOR_IDX_LANE_RATE), 8'(r), `CTOR_RESP_OKAY);
      rd(ba(`CTOR_IDX_LANE_RATE), 8'(r), `CTOR_RESP_OKAY);
      for (int k = 0; k < 6; k++) begin
        e = (k == 0) ? 7'h55 : 7'((dflt[k] * scale[r] + 4) >> 3);
        rd(ba(`CTOR_IDX_CLK_ZERO + k), {k == 0, e}, `CTOR_RESP_OKAY);
        chk("timing output", e, outv[k]);
      end
    end
    // an undefined rate code reads back as written but computes as 800
    wr(ba(`CTOR_IDX_LANE_RATE), 8'h07, `CTOR_RESP_OKAY);
    rd(ba(`CTOR_IDX_LANE_RATE), 8'h07, `CTOR_RESP_OKAY);
    rd(ba(`CTOR_IDX_CLK_TRAIL), {1'b0, dflt[1]}, `CTOR_RESP_OKAY);
    chk("timing output", dflt[1], outv[1]);
    wr(ba(`CTOR_IDX_CLK_ZERO), 8'h00, `CTOR_RESP_OKAY);
    wr(ba(`CTOR_IDX_LANE_RATE), 8'h01, `CTOR_RESP_OKAY);
    $display("test rate done");
  endtask
  // refused and masked writes leave the register alone
  task automatic t_errors();
    rd(12'h200, 8'h00, `CTOR_RESP_SLVERR);
    wr(ba(`CTOR_IDX_CLK_ZERO) + 12'h001, 8'hFF, `CTOR_RESP_SLVERR);
    wr(ba(`CTOR_IDX_LINK_STATUS), 8'hFF, `CTOR_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(ba(`CTOR_IDX_CLK_ZERO), 8'hFF, `CTOR_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ba(`CTOR_IDX_CLK_ZERO), {1'b0, dflt[0]}, `CTOR_RESP_OKAY);
    $display("test errors done");
  endtask
  // link alive follows the byte clock and drops after 64 quiet cycles
  task automatic t_link();
    phyEnable <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(ba(`CTOR_IDX_LINK_STATUS), 8'h01, `CTOR_RESP_OKAY);
    chk("alive output", 1'b1, byteClkAlive);
    phyEnable <= 1'b0;
    repeat (80) @(posedge sys_clk);
    rd(ba(`CTOR_IDX_LINK_STATUS), 8'h00, `CTOR_RESP_OKAY);
    chk("alive output", 1'b0, byteClkAlive);
    $display("test link done");
  endtask

  // --------------------------------
  // run control
  // --------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock, 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycleCount++;
    if (cycleCount == 8000) begin
      errors++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, phyEnable, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_override();
    t_rate();
    t_errors();
    t_link();
    end_sim();
  end
endmodule // tb_top
